// *** adc_start_control.sv ***
/*
 * Start-of-conversion control for the successive-approximation converter:
 * conversion clock selection, trigger selection, busy tracking, done flag,
 * result capture, switcher sync hold-off and burst power-up sequencing.
 * Assumes all inputs are synchronous to clk_sys, timer overflows and ticks
 * are one-cycle pulses, and the SAR core returns its code on sar_data by
 * the last conversion clock.
 */
// Notes on behaviour
// - Conversions never exceed 300 ksps.
// - Clock source: system clock, or oscillator in burst.
// - Divide ratio comes from divider field.
// - Select picks software, timer 0/2/3, or pin edge.
// - Writing busy starts; busy high while converting.
// - Busy falling sets done flag and interrupt.
// - Result pair valid while done flag set.
// - Timers 2/3: low overflow in 8-bit mode.
// - Sync mode delays start until switcher pulse.
// - Sync hold-off at most 625 ns.
// - Sync mode clocks conversion from switcher clock.
// - Sync clock invert bit inverts switcher clock.
// - Without burst, power follows converter enable only.
// - Burst with enable: stay powered, start immediately.
// - Burst without enable: sleep, power-up delay first.
// - Power-up delay is (field + 1) times 400 ns.
// - Power-up register bit 7 reads zero.
`timescale 1ns/10ps
`default_nettype none

module adc_start_control #(
	parameter int RESULT_W  = 10,
	parameter int CONV_CLKS = 14,
	parameter int DIV_W     = 5
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// Special function register port
	input  wire logic [3:0]          sfr_page,
	input  wire logic [7:0]          sfr_addr,
	input  wire logic                sfr_wr,
	input  wire logic                sfr_rd,
	input  wire logic [7:0]          sfr_wdata,
	output logic [7:0]               sfr_rdata,
	// Control bits
	input  wire logic                converter_enable,
	input  wire logic                burst_enable,
	input  wire logic [2:0]          start_source_select,
	input  wire logic [DIV_W-1:0]    clock_divider_field,
	input  wire logic                busy_write,
	input  wire logic                done_clear,
	input  wire logic                int_enable,
	input  wire logic                sync_enable,
	input  wire logic                one_cell_mode,
	input  wire logic                sync_clock_invert,
	// Trigger sources
	input  wire logic                timer0_ovf,
	input  wire logic                timer2_low_ovf,
	input  wire logic                timer2_high_ovf,
	input  wire logic                timer2_split,
	input  wire logic                timer3_low_ovf,
	input  wire logic                timer3_high_ovf,
	input  wire logic                timer3_split,
	input  wire logic                external_start_pin,
	// Clock sources
	input  wire logic                lpo_tick,
	input  wire logic                switcher_clk,
	input  wire logic                switcher_sync,
	// SAR core
	input  wire logic [RESULT_W-1:0] sar_data,
	output logic                     sar_clk_en,
	output logic                     sar_powered,
	// Status
	output logic                     conversion_busy,
	output logic                     conversion_done_flag,
	output logic                     irq,
	output logic [RESULT_W-1:0]      result_register_pair
);

	localparam int CLK_CNT_W = $clog2(CONV_CLKS + 1);
	localparam int HOLD_MAX  = adc_start_pkg::SYNC_HOLD_CYCLES;
	localparam logic [adc_start_pkg::CNT_W-1:0] MIN_CONV =
		adc_start_pkg::CNT_W'(adc_start_pkg::MIN_CONV_CYCLES);
	localparam logic [adc_start_pkg::CNT_W-1:0] HOLD_LAST =
		adc_start_pkg::CNT_W'(adc_start_pkg::SYNC_HOLD_CYCLES - 1);
	localparam logic [adc_start_pkg::CNT_W-1:0] PWR_STEP =
		adc_start_pkg::CNT_W'(adc_start_pkg::PWRUP_STEP_CYCLES);
	localparam logic [CLK_CNT_W-1:0] CLKS_LAST = CLK_CNT_W'(CONV_CLKS);

	// ------------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------------
	generate
		if (RESULT_W < 1 || RESULT_W > 16 || CONV_CLKS < 1 || DIV_W < 1)
		begin : g_bad_param
			$error("adc_start_control: unsupported parameter values");
		end
	endgenerate

	typedef struct packed {
		adc_start_pkg::conv_state_e st;
		logic [adc_start_pkg::CNT_W-1:0] cnt;
		logic [CLK_CNT_W-1:0]            clk_cnt;
		logic                            pin_prev;
		logic                            sw_prev;
		logic                            done;
		logic [RESULT_W-1:0]             result;
		logic [adc_start_pkg::PWRUP_FIELD_W-1:0] pwr;
		logic [7:0]                      rdata;
	} ctl_state_s;

	ctl_state_s r;
	ctl_state_s next_r;

	logic                            sync_on;
	logic                            sw_edge;
	logic                            src_tick;
	logic                            conv_tick;
	logic                            trig;
	logic                            trig_ok;
	logic                            need_power;
	logic [adc_start_pkg::CNT_W-1:0] pwr_cycles;
	logic                            sfr_hit;

	// Pick the overflow that matches the timer's width mode
	function automatic logic timer_ovf(input logic split, input logic lo, input logic hi);
		timer_ovf = split ? lo : hi;
	endfunction : timer_ovf

	// ------------------------------------------------------------------
	// Clock source and divider
	// ------------------------------------------------------------------
	// Sync only valid in one-cell mode; sync_enable is ignored in two-cell mode
	assign sync_on = sync_enable & one_cell_mode;
	// Switcher edge, optionally the falling one to dodge switching noise
	assign sw_edge = sync_clock_invert ? (r.sw_prev & ~switcher_clk)
	                                   : (~r.sw_prev & switcher_clk);
	// Source tick: switcher in sync, oscillator in burst, else system clock
	assign src_tick = sync_on ? sw_edge : (burst_enable ? lpo_tick : 1'b1);

	conv_clock_divider #(
		.DIV_W (DIV_W)
	) u_div (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.src_tick (src_tick),
		.divide   (clock_divider_field),
		.tick     (conv_tick)
	);

	// ------------------------------------------------------------------
	// Trigger selection
	// ------------------------------------------------------------------
	always_comb
	begin
		case (start_source_select)
			adc_start_pkg::SRC_SOFTWARE: trig = busy_write;
			adc_start_pkg::SRC_TIMER0:   trig = timer0_ovf;
			adc_start_pkg::SRC_TIMER2:
				trig = timer_ovf(timer2_split, timer2_low_ovf, timer2_high_ovf);
			adc_start_pkg::SRC_TIMER3:
				trig = timer_ovf(timer3_split, timer3_low_ovf, timer3_high_ovf);
			adc_start_pkg::SRC_EXT_PIN:  trig = external_start_pin & ~r.pin_prev;
			default:                     trig = 1'b0;
		endcase
	end

	// Unpowered converter outside burst cannot run; busy also blocks
	assign trig_ok    = trig && r.st == adc_start_pkg::ST_IDLE
	                    && (burst_enable || converter_enable);
	assign need_power = burst_enable & ~converter_enable;
	assign pwr_cycles = (adc_start_pkg::CNT_W'(r.pwr) + 1'b1) * PWR_STEP;
	assign sfr_hit    = sfr_page == adc_start_pkg::PWRUP_PAGE
	                    && sfr_addr == adc_start_pkg::PWRUP_ADDR;

	// ------------------------------------------------------------------
	// Sequencer, flags and register file
	// ------------------------------------------------------------------
	always_comb
	begin
		next_r          = r;
		next_r.pin_prev = external_start_pin;
		next_r.sw_prev  = switcher_clk;
		next_r.done     = r.done & ~done_clear;
		case (r.st)
			adc_start_pkg::ST_IDLE:
			begin
				next_r.cnt = '0;
				if (trig_ok)
				begin
					if (sync_on)
						next_r.st = adc_start_pkg::ST_SYNC;
					else if (need_power)
						next_r.st = adc_start_pkg::ST_POWER;
					else
					begin
						next_r.st      = adc_start_pkg::ST_CONVERT;
						next_r.clk_cnt = '0;
					end
				end
			end
			adc_start_pkg::ST_SYNC:
			begin
				// Give up waiting after one slow switcher period
				if (switcher_sync || r.cnt >= HOLD_LAST)
				begin
					next_r.cnt     = '0;
					next_r.clk_cnt = '0;
					next_r.st      = need_power ? adc_start_pkg::ST_POWER
					                            : adc_start_pkg::ST_CONVERT;
				end
				else
					next_r.cnt = r.cnt + 1'b1;
			end
			adc_start_pkg::ST_POWER:
			begin
				if (r.cnt >= pwr_cycles - 1'b1)
				begin
					next_r.cnt     = '0;
					next_r.clk_cnt = '0;
					next_r.st      = adc_start_pkg::ST_CONVERT;
				end
				else
					next_r.cnt = r.cnt + 1'b1;
			end
			adc_start_pkg::ST_CONVERT:
			begin
				// Counter saturates; it only guards the rate floor
				if (r.cnt < MIN_CONV)
					next_r.cnt = r.cnt + 1'b1;
				if (conv_tick && r.clk_cnt < CLKS_LAST)
					next_r.clk_cnt = r.clk_cnt + 1'b1;
				if (r.clk_cnt == CLKS_LAST && r.cnt >= MIN_CONV - 1'b1)
				begin
					next_r.st     = adc_start_pkg::ST_IDLE;
					next_r.done   = 1'b1;
					next_r.result = sar_data;
				end
			end
			default:
				next_r.st = adc_start_pkg::ST_IDLE;
		endcase
		// Only the low field is stored; reserved and unused bits drop
		if (sfr_wr && sfr_hit)
			next_r.pwr = sfr_wdata[adc_start_pkg::PWRUP_FIELD_W-1:0];
		if (sfr_rd)
			next_r.rdata = sfr_hit ? {4'h0, r.pwr} : 8'h00;
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			r     <= '0;
			r.st  <= adc_start_pkg::ST_IDLE;
			r.pwr <= adc_start_pkg::PWRUP_RESET;
		end
		else
			r <= next_r;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign conversion_busy      = r.st != adc_start_pkg::ST_IDLE;
	assign conversion_done_flag = r.done;
	assign irq                  = r.done & int_enable;
	assign result_register_pair = r.result;
	assign sfr_rdata            = r.rdata;
	assign sar_clk_en           = conv_tick && r.st == adc_start_pkg::ST_CONVERT;
	// Burst keeps the core up only while powering up or converting (not in sync hold) unless the enable holds it
	assign sar_powered = burst_enable ? (converter_enable
	                     || (r.st != adc_start_pkg::ST_IDLE && r.st != adc_start_pkg::ST_SYNC))
	                     : converter_enable;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sw_start_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		busy_write && start_source_select == adc_start_pkg::SRC_SOFTWARE
		&& !conversion_busy && converter_enable
		|=> conversion_busy)
		else $error("software start did not raise busy");

	done_on_fall_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		$fell(conversion_busy) |-> conversion_done_flag && irq == int_enable)
		else $error("busy fell without done flag");

	result_capture_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		$fell(conversion_busy) |-> result_register_pair == $past(sar_data))
		else $error("result not captured at completion");

	no_restart_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		r.st == adc_start_pkg::ST_CONVERT && r.clk_cnt != '0
		|=> r.clk_cnt != '0 || r.st == adc_start_pkg::ST_IDLE)
		else $error("conversion restarted while busy");

	sync_bound_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(r.st == adc_start_pkg::ST_SYNC)
		|-> ##[1:HOLD_MAX] r.st != adc_start_pkg::ST_SYNC)
		else $error("sync hold-off too long");

	powerup_len_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		$fell(r.st == adc_start_pkg::ST_POWER)
		|-> $past(r.cnt) == $past(pwr_cycles) - 1'b1)
		else $error("power-up delay length wrong");

	burst_direct_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		trig_ok && burst_enable && converter_enable && !sync_on
		|=> r.st == adc_start_pkg::ST_CONVERT)
		else $error("burst enabled start was delayed");

	rate_floor_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		$fell(conversion_busy) |-> $past(r.cnt) >= MIN_CONV - 1'b1)
		else $error("conversion shorter than rate limit");

	power_follow_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!burst_enable |-> sar_powered == converter_enable)
		else $error("power state ignores enable");

	reserved_zero_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		$past(sfr_rd) |-> sfr_rdata[adc_start_pkg::RSVD_BIT] == 1'b0)
		else $error("reserved bit read as one");

endmodule : adc_start_control

`default_nettype wire

// *** adc_start_pkg.sv ***
/*
 * Shared constants for the converter start-of-conversion control: the
 * power-up time register location, field layout, start source codes,
 * sequencer states and the timing counts at the 100 MHz system clock.
 * Assumes a 10 ns system clock period.
 */
package adc_start_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] PWRUP_ADDR    = 8'hba;
	localparam logic [3:0] PWRUP_PAGE    = 4'hf;
	localparam logic [3:0] PWRUP_RESET   = 4'hf;
	localparam int         PWRUP_FIELD_W = 4;
	localparam int         RSVD_BIT      = 7;

	// ------------------------------------------------------------------
	// Start source select codes
	// ------------------------------------------------------------------
	localparam logic [2:0] SRC_SOFTWARE = 3'h0;
	localparam logic [2:0] SRC_TIMER0   = 3'h1;
	localparam logic [2:0] SRC_TIMER2   = 3'h2;
	localparam logic [2:0] SRC_TIMER3   = 3'h3;
	localparam logic [2:0] SRC_EXT_PIN  = 3'h4;

	// ------------------------------------------------------------------
	// Sequencer states, Gray coded along idle-sync-power-convert
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SYNC    = 2'b01,
		ST_POWER   = 2'b11,
		ST_CONVERT = 2'b10
	} conv_state_e;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CNT_W         = 10;
	// Fastest sample rate; a conversion never ends sooner than this allows
	localparam int MAX_RATE_KSPS = 300;
	localparam int MIN_CONV_CYCLES =
		(1000000 + MAX_RATE_KSPS * CLK_PERIOD_NS - 1) / (MAX_RATE_KSPS * CLK_PERIOD_NS);
	// Longest sync hold-off, one switcher period at its slowest
	localparam int SYNC_HOLD_NS     = 625;
	localparam int SYNC_HOLD_CYCLES = SYNC_HOLD_NS / CLK_PERIOD_NS;
	// Burst power-up step per count of the power-up field
	localparam int PWRUP_STEP_NS     = 400;
	localparam int PWRUP_STEP_CYCLES = (PWRUP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : adc_start_pkg

// *** conv_clock_divider.sv ***
/*
 * Conversion clock divider: counts source ticks and emits one enable pulse
 * every (divide + 1) source ticks.
 * Assumes src_tick is a one-cycle enable synchronous to clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

module conv_clock_divider #(
	parameter int DIV_W = 5
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             src_tick,
	input  wire logic [DIV_W-1:0] divide,
	output logic                  tick
);

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} div_state_s;

	div_state_s r;
	div_state_s next_r;

	generate
		if (DIV_W < 1)
		begin : g_bad_width
			$error("conv_clock_divider: DIV_W must be at least 1");
		end
	endgenerate

	// Ratio taken live from the divider field, so a change applies to the count in progress
	always_comb
	begin
		next_r      = r;
		next_r.tick = 1'b0;
		if (src_tick)
		begin
			if (r.cnt >= divide)
			begin
				next_r.cnt  = '0;
				next_r.tick = 1'b1;
			end
			else
			begin
				next_r.cnt = r.cnt + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign tick = r.tick;

endmodule : conv_clock_divider

`default_nettype wire

// *** tb_adc_start_control.sv ***
/*
 * Self-checking testbench for adc_start_control: power-up register, trigger
 * sources, busy and done sequencing, divider, burst power-up and sync hold.
 * Assumes adc_start_pkg is compiled first; the bench drives every port.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_adc_start_control;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int LIMIT = 30000;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  sfr_page = 4'h0;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [7:0]  sfr_rdata;
	logic        converter_enable = 1'b1;
	logic        burst_enable = 1'b0;
	logic [2:0]  start_source_select = 3'h0;
	logic [4:0]  clock_divider_field = 5'h00;
	logic        busy_write = 1'b0;
	logic        done_clear = 1'b0;
	logic        int_enable = 1'b1;
	logic        sync_enable = 1'b0;
	logic        one_cell_mode = 1'b1;
	logic        sync_clock_invert = 1'b0;
	logic        timer0_ovf = 1'b0;
	logic        timer2_low_ovf = 1'b0;
	logic        timer2_high_ovf = 1'b0;
	logic        timer2_split = 1'b0;
	logic        timer3_low_ovf = 1'b0;
	logic        timer3_high_ovf = 1'b0;
	logic        timer3_split = 1'b0;
	logic        external_start_pin = 1'b0;
	logic        lpo_tick = 1'b0;
	logic        switcher_clk = 1'b0;
	logic        switcher_sync = 1'b0;
	logic [9:0]  sar_data = 10'h2a5;
	logic        sar_clk_en;
	logic        sar_powered;
	logic        conversion_busy;
	logic        conversion_done_flag;
	logic        irq;
	logic [9:0]  result_register_pair;
	logic [15:0] cycle_count = 16'h0000;
	int          fails = 0;
	int          check_count = 0;

	adc_start_control u_dut (
		.clk_sys(clk_sys), .rst(rst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.converter_enable(converter_enable), .burst_enable(burst_enable),
		.start_source_select(start_source_select), .clock_divider_field(clock_divider_field),
		.busy_write(busy_write), .done_clear(done_clear), .int_enable(int_enable),
		.sync_enable(sync_enable), .one_cell_mode(one_cell_mode),
		.sync_clock_invert(sync_clock_invert), .timer0_ovf(timer0_ovf),
		.timer2_low_ovf(timer2_low_ovf),
		.timer2_high_ovf(timer2_high_ovf), .timer2_split(timer2_split),
		.timer3_low_ovf(timer3_low_ovf), .timer3_high_ovf(timer3_high_ovf),
		.timer3_split(timer3_split), .external_start_pin(external_start_pin),
		.lpo_tick(lpo_tick), .switcher_clk(switcher_clk), .switcher_sync(switcher_sync),
		.sar_data(sar_data), .sar_clk_en(sar_clk_en), .sar_powered(sar_powered),
		.conversion_busy(conversion_busy), .conversion_done_flag(conversion_done_flag),
		.irq(irq), .result_register_pair(result_register_pair)
	);

	// ----------------------------------------------------------------
	// Clocks and watchdog
	// ----------------------------------------------------------------
	// System clock, 10 ns period
	always #5 clk_sys = ~clk_sys;

	// Oscillator tick every 4 cycles, switcher clock period 32 cycles
	always @(posedge clk_sys)
	begin
		cycle_count <= cycle_count + 16'h0001;
		lpo_tick <= (cycle_count[1:0] == 2'h3);
		switcher_clk <= cycle_count[4];
		if (cycle_count == 16'(LIMIT))
		begin
			fails++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Inputs change 1 ns after the edge so the sample never races
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask : step

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic sfr_write(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] d);
		sfr_page = pg;
		sfr_addr = ad;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		step();
		sfr_wr = 1'b0;
	endtask : sfr_write

	task automatic sfr_read(input logic [3:0] pg, input logic [7:0] ad, output logic [7:0] d);
		sfr_page = pg;
		sfr_addr = ad;
		sfr_rd = 1'b1;
		step();
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask : sfr_read

	// One-cycle pulse on the chosen trigger input
	task automatic fire(input int which);
		case (which)
			0: busy_write = 1'b1;
			1: timer0_ovf = 1'b1;
			2: timer2_low_ovf = 1'b1;
			3: timer2_high_ovf = 1'b1;
			4: timer3_low_ovf = 1'b1;
			5: timer3_high_ovf = 1'b1;
			default: external_start_pin = 1'b1; // pin kept off the crossbar
		endcase
		step();
		{busy_write, timer0_ovf, timer2_low_ovf, timer2_high_ovf} = 4'h0;
		{timer3_low_ovf, timer3_high_ovf, external_start_pin} = 3'h0;
	endtask : fire

	// Bounded waits; a hang shows up as an out-of-range count
	task automatic wait_done(output int n);
		n = 0;
		while (conversion_done_flag !== 1'b1 && n < 3000)
		begin
			step();
			n++;
		end
		check("done_seen", 16'h0001, 16'(conversion_done_flag));
		done_clear = 1'b1;
		step();
		done_clear = 1'b0;
	endtask : wait_done

	task automatic first_tick(output int n);
		n = 0;
		while (sar_clk_en !== 1'b1 && n < 500)
		begin
			step();
			n++;
		end
	endtask : first_tick

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_registers();
		logic [7:0] d;
		sfr_read(4'hf, 8'hba, d);
		check("pwr_reset", 16'h000f, 16'(d));
		sfr_write(4'hf, 8'hba, 8'h75); // bit 7 written as zero
		sfr_read(4'hf, 8'hba, d);
		check("pwr_upper_zero", 16'h0005, 16'(d));
		sfr_write(4'h0, 8'hba, 8'h03);
		sfr_read(4'hf, 8'hba, d);
		check("pwr_wrong_page", 16'h0005, 16'(d));
		sfr_read(4'hf, 8'h55, d);
		check("unmapped_read", 16'h0000, 16'(d));
		$display("test registers done");
	endtask : test_registers

	// Select codes 0 to 4 against their matching trigger, codes 1 to 5 against a non-matching one
	task automatic test_sources();
		int sel_t[13] = '{0, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 5, 4};
		int src_t[13] = '{0, 1, 0, 2, 3, 3, 2, 4, 5, 5, 6, 0, 1};
		int spl_t[13] = '{0, 0, 0, 1, 1, 0, 0, 1, 1, 0, 0, 0, 0};
		int exp_t[13] = '{1, 1, 0, 1, 0, 1, 0, 1, 0, 1, 1, 0, 0};
		logic s;
		int n;
		for (int i = 0; i < 13; i++)
		begin
			start_source_select = 3'(sel_t[i]);
			timer2_split = spl_t[i][0];
			timer3_split = spl_t[i][0];
			fire(src_t[i]);
			s = (conversion_busy === 1'b1);
			repeat (3)
			begin
				step();
				s = s | (conversion_busy === 1'b1);
			end
			check("trigger_start", 16'(exp_t[i]), 16'(s));
			if (s)
				wait_done(n);
		end
		start_source_select = 3'h0;
		$display("test sources done");
	endtask : test_sources

	task automatic test_software();
		int n;
		sar_data = 10'h2a5;
		fire(0);
		check("busy_set", 16'h0001, 16'(conversion_busy));
		check("done_low_busy", 16'h0000, 16'(conversion_done_flag));
		n = 0;
		while (conversion_done_flag !== 1'b1 && n < 3000)
		begin
			step();
			n++;
		end
		check("busy_clear", 16'h0000, 16'(conversion_busy));
		check("irq_on_done", 16'h0001, 16'(irq));
		check("result", 16'h02a5, 16'(result_register_pair));
		check("rate_floor", 16'h0001, 16'(n >= adc_start_pkg::MIN_CONV_CYCLES - 2));
		check("rate_ceil", 16'h0001, 16'(n <= adc_start_pkg::MIN_CONV_CYCLES + 10));
		int_enable = 1'b0;
		step();
		check("irq_masked", 16'h0000, 16'(irq));
		int_enable = 1'b1;
		wait_done(n);
		check("done_cleared", 16'h0000, 16'(conversion_done_flag));
		$display("test software done");
	endtask : test_software

	// A second request mid-conversion must not stretch or repeat it
	task automatic test_ignore();
		int n;
		fire(0);
		repeat (50) step();
		fire(0);
		sar_data = 10'h13c;
		wait_done(n);
		check("no_restart", 16'h0001, 16'(n <= adc_start_pkg::MIN_CONV_CYCLES - 40));
		check("result_second", 16'h013c, 16'(result_register_pair));
		repeat (3) step();
		check("no_second", 16'h0000, 16'(conversion_busy));
		$display("test ignore done");
	endtask : test_ignore

	task automatic test_divider();
		int n;
		int k;
		clock_divider_field = 5'h03;
		fire(0);
		first_tick(n);
		step();
		first_tick(k);
		check("divide_gap", 16'h0004, 16'(k + 1));
		wait_done(n);
		clock_divider_field = 5'h00;
		$display("test divider done");
	endtask : test_divider

	task automatic test_power();
		logic s;
		converter_enable = 1'b0;
		step();
		check("unpowered", 16'h0000, 16'(sar_powered));
		fire(0);
		s = (conversion_busy === 1'b1);
		repeat (3) step();
		check("dropped", 16'h0000, 16'(s | (conversion_busy === 1'b1)));
		converter_enable = 1'b1;
		step();
		check("powered", 16'h0001, 16'(sar_powered));
		$display("test power done");
	endtask : test_power

	task automatic test_burst();
		int n;
		int k;
		burst_enable = 1'b1;
		step();
		check("burst_on_idle", 16'h0001, 16'(sar_powered));
		fire(0);
		first_tick(n);
		check("burst_prompt", 16'h0001, 16'(n <= 8));
		wait_done(n);
		converter_enable = 1'b0;
		sfr_write(4'hf, 8'hba, 8'h02);
		step();
		check("burst_sleep", 16'h0000, 16'(sar_powered));
		fire(0);
		check("burst_wake", 16'h0001, 16'(sar_powered));
		first_tick(n);
		check("pwrup_min", 16'h0001, 16'(n >= 3 * adc_start_pkg::PWRUP_STEP_CYCLES - 1));
		check("pwrup_max", 16'h0001, 16'(n <= 3 * adc_start_pkg::PWRUP_STEP_CYCLES + 8));
		step();
		first_tick(k);
		check("lpo_gap", 16'h0004, 16'(k + 1));
		wait_done(n);
		check("burst_resleep", 16'h0000, 16'(sar_powered));
		burst_enable = 1'b0;
		converter_enable = 1'b1;
		$display("test burst done");
	endtask : test_burst

	task automatic test_sync();
		int n;
		logic seen;
		clock_divider_field = 5'h00;
		one_cell_mode = 1'b1;
		sync_enable = 1'b1;
		fire(0);
		seen = 1'b0;
		repeat (20)
		begin
			seen = seen | (sar_clk_en === 1'b1);
			step();
		end
		check("sync_hold", 16'h0000, 16'(seen));
		switcher_sync = 1'b1;
		step();
		switcher_sync = 1'b0;
		first_tick(n);
		check("sync_release", 16'h0001, 16'(n <= 40));
		// Tick follows a rising switcher edge, so the clock still reads high
		check("sync_rise_edge", 16'h0001, 16'(switcher_clk));
		wait_done(n);
		sync_clock_invert = 1'b1;
		fire(0);
		first_tick(n);
		check("sync_timeout", 16'h0001, 16'(n <= adc_start_pkg::SYNC_HOLD_CYCLES + 40));
		check("sync_fall_edge", 16'h0000, 16'(switcher_clk));
		wait_done(n);
		sync_enable = 1'b0;
		sync_clock_invert = 1'b0;
		$display("test sync done");
	endtask : test_sync

	// ----------------------------------------------------------------
	// Verdict and main sequence
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		repeat (16) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		step();
		test_registers();
		test_sources();
		test_software();
		test_ignore();
		test_divider();
		test_power();
		test_burst();
		test_sync();
		print_verdict();
	end

endmodule : tb_adc_start_control

`default_nettype wire
